// [sfr_fault_response.sv]
// Fault response logic: actions, restarts, status bits and alert line
`timescale 1ns/10ps
`include "sfr_regs.svh"
module sfr_fault_response #(
    parameter int TICK_CYCLES = `SFR_TICK_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        measValid,
    input  wire logic        overTempDet,
    input  wire logic        underTempDet,
    input  wire logic        inputOvervoltDet,
    input  wire logic        inputUndervoltDet,
    input  wire logic        startupTimeoutDet,
    input  wire logic        channelOnPin,
    input  wire logic        operationOn,
    input  wire logic        seqOffSelect,
    input  wire logic        seqOffDone,
    input  wire logic [2:0]  retryLimit,
    input  wire logic [15:0] retryDelayTicks,
    input  wire logic [3:0]  regSel,
    input  wire logic        regWrStb,
    input  wire logic [7:0]  regWrData,
    output logic      [7:0]  regRdData,
    output logic             host_alert_line_n,
    output logic             channelEnable,
    output logic             seqOffRequest
);
    sfr_pkg::sfr_state_type state;
    sfr_pkg::sfr_state_type next_state;
    sfr_pkg::sfr_fault_type faultSticky;
    sfr_pkg::sfr_fault_type next_faultSticky;
    sfr_pkg::sfr_fault_type cause;
    sfr_pkg::sfr_fault_type next_cause;
    logic [7:3]  actionReg [5];
    logic [7:3]  next_actionReg [5];
    logic [2:0]  activeRetry [5];
    logic [2:0]  next_activeRetry [5];
    logic [2:0]  retryCnt;
    logic [2:0]  next_retryCnt;
    logic        onSyncA;
    logic        onSync;
    logic        tick;
    logic        retryDone;
    logic        quietDone;
    logic [15:0] retryLimitTicks;
    logic [7:0]  next_rdData;
    logic        next_alertN;
    logic        next_enable;
    logic        next_seqReq;
    logic        cmdOn;
    sfr_pkg::sfr_fault_type faultVec;
    sfr_pkg::sfr_fault_type shutVec;
    sfr_pkg::sfr_fault_type firstShut;
    sfr_pkg::sfr_fault_type clearMask;
    logic [7:0]  statusByte;
    logic [7:0]  wordHigh;
    logic [7:0]  statusVin;
    logic [7:0]  statusTemp;
    logic [7:0]  statusVout;

    // Restart allowed by the selected retry field and the global limit
    function automatic logic restart_ok(input logic [2:0] retryField,
                                        input logic [2:0] limit,
                                        input logic [2:0] cnt);
        restart_ok = (retryField != 3'h0) &&
                     ((limit == `SFR_RETRY_INFINITE) || (cnt < limit));
    endfunction

    // Retry field of the one-hot selected fault
    function automatic logic [2:0] pick_retry(input sfr_pkg::sfr_fault_type sel,
                                              input logic [2:0] fields [5]);
        pick_retry = 3'h0;
        for (int i = 0; i < 5; i++) begin
            if (sel[i])
                pick_retry = pick_retry | fields[i];
        end
    endfunction

    sfr_tick_div #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clock (clock),
        .rst_b (rst_b),
        .tick  (tick)
    );

    // Interval clamped to its ceiling; steps are already 200 us
    assign retryLimitTicks = (retryDelayTicks > 16'(`SFR_RETRY_MAX_TICK)) ?
                             16'(`SFR_RETRY_MAX_TICK) : retryDelayTicks;

    sfr_interval #(
        .W (16)
    ) u_retry_delay (
        .clock (clock),
        .rst_b (rst_b),
        .tick  (tick),
        .clear (state != sfr_pkg::SFR_RETRY_WAIT),
        .limit (retryLimitTicks),
        .done  (retryDone)
    );

    sfr_interval #(
        .W (16)
    ) u_quiet (
        .clock (clock),
        .rst_b (rst_b),
        .tick  (tick),
        .clear (state != sfr_pkg::SFR_RUN),
        .limit (16'(`SFR_QUIET_TICK)),
        .done  (quietDone)
    );

    always_comb begin
        cmdOn = onSync && operationOn;
        // Only converter-sampled values feed these four
        faultVec = {startupTimeoutDet,
                    {4{measValid}} & {inputUndervoltDet, inputOvervoltDet,
                                      underTempDet, overTempDet}};
        for (int i = 0; i < 5; i++) begin
            shutVec[i] = faultVec[i] &&
                         (actionReg[i][`SFR_ACTION_MSB:`SFR_ACTION_LSB] != 2'h0);
        end
        firstShut = shutVec & (~shutVec + 5'h01);

        // Write-one-to-clear of the specific fault bits
        clearMask = 5'h00;
        if (regWrStb) begin
            case (regSel)
                `SFR_SEL_STATUS_TEMP: begin
                    clearMask[`SFR_IDX_OT] = regWrData[`SFR_STAT_OV_FAULT];
                    clearMask[`SFR_IDX_UT] = regWrData[`SFR_STAT_UV_FAULT];
                end
                `SFR_SEL_STATUS_VIN: begin
                    clearMask[`SFR_IDX_VIN_OV] = regWrData[`SFR_STAT_OV_FAULT];
                    clearMask[`SFR_IDX_VIN_UV] = regWrData[`SFR_STAT_UV_FAULT];
                end
                `SFR_SEL_STATUS_VOUT: begin
                    clearMask[`SFR_IDX_TON] = regWrData[`SFR_STAT_TON_FAULT];
                end
                default: begin
                    clearMask = 5'h00;
                end
            endcase
        end
        // Set beats clear so a fault in the clearing cycle survives
        next_faultSticky = (faultSticky & ~clearMask) | faultVec;

        for (int i = 0; i < 5; i++) begin
            next_actionReg[i] = actionReg[i];
            if (regWrStb && (regSel == 4'(i)))
                next_actionReg[i] = regWrData[7:3];
        end
    end

    // Unit sequencing through shutdown and restart
    always_comb begin
        next_state       = state;
        next_cause       = cause;
        next_retryCnt    = retryCnt;
        next_activeRetry = activeRetry;
        if (quietDone)
            next_retryCnt = 3'h0;
        case (state)
            sfr_pkg::SFR_OFF: begin
                if (cmdOn) begin
                    next_state    = sfr_pkg::SFR_RUN;
                    next_retryCnt = 3'h0;
                    // Retry fields take effect only on a fresh turn-on
                    for (int i = 0; i < 5; i++) begin
                        next_activeRetry[i] = actionReg[i][`SFR_RETRY_MSB:`SFR_RETRY_LSB];
                    end
                end
            end
            sfr_pkg::SFR_RUN: begin
                if (!cmdOn) begin
                    next_state = sfr_pkg::SFR_OFF;
                end else if (shutVec != 5'h00) begin
                    next_cause = firstShut;
                    if (seqOffSelect) begin
                        next_state = sfr_pkg::SFR_SEQ_OFF;
                    end else if (restart_ok(pick_retry(firstShut, activeRetry),
                                            retryLimit, retryCnt)) begin
                        next_state = sfr_pkg::SFR_RETRY_WAIT;
                        if (retryLimit != `SFR_RETRY_INFINITE)
                            next_retryCnt = retryCnt + 3'h1;
                    end else begin
                        next_state = sfr_pkg::SFR_HOLD;
                    end
                end
            end
            sfr_pkg::SFR_SEQ_OFF: begin
                if (!cmdOn) begin
                    next_state = sfr_pkg::SFR_OFF;
                end else if (seqOffDone) begin
                    if (restart_ok(pick_retry(cause, activeRetry),
                                   retryLimit, retryCnt)) begin
                        next_state = sfr_pkg::SFR_RETRY_WAIT;
                        if (retryLimit != `SFR_RETRY_INFINITE)
                            next_retryCnt = retryCnt + 3'h1;
                    end else begin
                        next_state = sfr_pkg::SFR_HOLD;
                    end
                end
            end
            sfr_pkg::SFR_RETRY_WAIT: begin
                if (!cmdOn) begin
                    next_state = sfr_pkg::SFR_OFF;
                end else if (shutVec != 5'h00) begin
                    next_cause = firstShut;
                    next_state = sfr_pkg::SFR_HOLD;
                end else if (retryDone) begin
                    next_state = sfr_pkg::SFR_RUN;
                end
            end
            sfr_pkg::SFR_HOLD: begin
                // Held off until the host clears the causing fault bit
                if (!cmdOn)
                    next_state = sfr_pkg::SFR_OFF;
                else if ((next_faultSticky & cause) == 5'h00)
                    next_state = sfr_pkg::SFR_RUN;
            end
            default: begin
                next_state = sfr_pkg::SFR_OFF;
            end
        endcase
        next_enable = (next_state == sfr_pkg::SFR_RUN) ||
                      (next_state == sfr_pkg::SFR_SEQ_OFF);
        next_seqReq = (next_state == sfr_pkg::SFR_SEQ_OFF);
    end

    // Status views and read data
    always_comb begin
        statusTemp = 8'h00;
        statusVin  = 8'h00;
        statusVout = 8'h00;
        statusTemp[`SFR_STAT_OV_FAULT] = faultSticky[`SFR_IDX_OT];
        statusTemp[`SFR_STAT_UV_FAULT] = faultSticky[`SFR_IDX_UT];
        statusVin[`SFR_STAT_OV_FAULT]  = faultSticky[`SFR_IDX_VIN_OV];
        statusVin[`SFR_STAT_UV_FAULT]  = faultSticky[`SFR_IDX_VIN_UV];
        statusVout[`SFR_STAT_TON_FAULT] = faultSticky[`SFR_IDX_TON];
        statusByte = 8'h00;
        statusByte[`SFR_BYTE_TEMP]      = |statusTemp;
        statusByte[`SFR_BYTE_VIN_UV]    = faultSticky[`SFR_IDX_VIN_UV];
        wordHigh = 8'h00;
        wordHigh[`SFR_HIGH_INPUT] = |statusVin;
        wordHigh[`SFR_HIGH_VOUT]  = |statusVout;
        statusByte[`SFR_BYTE_HIGH_BYTE] = |wordHigh;

        case (regSel)
            `SFR_SEL_OT_ACTION,
            `SFR_SEL_UT_ACTION,
            `SFR_SEL_VIN_OV_ACTION,
            `SFR_SEL_VIN_UV_ACTION,
            `SFR_SEL_TON_ACTION: begin
                next_rdData = {actionReg[regSel[2:0]], `SFR_DEGLITCH_RD};
            end
            `SFR_SEL_STATUS_BYTE: next_rdData = statusByte;
            `SFR_SEL_WORD_LOW:    next_rdData = statusByte;
            `SFR_SEL_WORD_HIGH:   next_rdData = wordHigh;
            `SFR_SEL_STATUS_VIN:  next_rdData = statusVin;
            `SFR_SEL_STATUS_TEMP: next_rdData = statusTemp;
            `SFR_SEL_STATUS_VOUT: next_rdData = statusVout;
            `SFR_SEL_UNIT_STATE:  next_rdData = {state, retryCnt};
            default:              next_rdData = 8'h00;
        endcase
        // Alert follows pending bits, so it holds until every one is cleared
        next_alertN = ~(|next_faultSticky);
    end

    // Control pin crosses in from outside: two flops first
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            onSyncA <= 1'b0;
            onSync  <= 1'b0;
        end else begin
            onSyncA <= channelOnPin;
            onSync  <= onSyncA;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state             <= sfr_pkg::SFR_OFF;
            cause             <= 5'h00;
            retryCnt          <= 3'h0;
            faultSticky       <= 5'h00;
            regRdData         <= 8'h00;
            host_alert_line_n <= 1'b1;
            channelEnable     <= 1'b0;
            seqOffRequest     <= 1'b0;
            for (int i = 0; i < 5; i++) begin
                actionReg[i]   <= 5'(`SFR_ACTION_RESET >> 3);
                activeRetry[i] <= 3'h0;
            end
        end else begin
            state             <= next_state;
            cause             <= next_cause;
            retryCnt          <= next_retryCnt;
            faultSticky       <= next_faultSticky;
            regRdData         <= next_rdData;
            host_alert_line_n <= next_alertN;
            channelEnable     <= next_enable;
            seqOffRequest     <= next_seqReq;
            actionReg         <= next_actionReg;
            activeRetry       <= next_activeRetry;
        end
    end
endmodule // sfr_fault_response

// [sfr_fault_response_assertions.sv]
// Checker for the fault response block ports
`timescale 1ns/10ps
`include "sfr_regs.svh"
module sfr_fault_response_assertions #(
    parameter int TICK_CYCLES = `SFR_TICK_CYCLES
) (
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic        measValid,
    input wire logic        overTempDet,
    input wire logic        underTempDet,
    input wire logic        inputOvervoltDet,
    input wire logic        inputUndervoltDet,
    input wire logic        startupTimeoutDet,
    input wire logic        channelOnPin,
    input wire logic        operationOn,
    input wire logic        seqOffSelect,
    input wire logic        seqOffDone,
    input wire logic [2:0]  retryLimit,
    input wire logic [15:0] retryDelayTicks,
    input wire logic [3:0]  regSel,
    input wire logic        regWrStb,
    input wire logic [7:0]  regWrData,
    input wire logic [7:0]  regRdData,
    input wire logic        host_alert_line_n,
    input wire logic        channelEnable,
    input wire logic        seqOffRequest
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic anyMeas;
    assign anyMeas = measValid && (overTempDet || underTempDet
                     || inputOvervoltDet || inputUndervoltDet);

    meas_alert_a: assert property (anyMeas |=> !host_alert_line_n)
        else $error("alert not low after measured fault");
    ton_alert_a: assert property (startupTimeoutDet |=> !host_alert_line_n)
        else $error("alert not low after timeout fault");
    alert_cause_a: assert property ($fell(host_alert_line_n) |->
        $past(startupTimeoutDet || anyMeas))
        else $error("alert fell without a qualified fault");
    // Allow two cycles after a write, the clear may lag by one
    alert_sticky_a: assert property (!host_alert_line_n && !regWrStb
        && !$past(regWrStb) |=> !host_alert_line_n)
        else $error("alert released without a host write");
    deglitch_zero_a: assert property (regSel <= `SFR_SEL_TON_ACTION |=>
        regRdData[2:0] == 3'h0)
        else $error("deglitch field not zero");
    seq_enable_a: assert property (seqOffRequest |-> channelEnable)
        else $error("enable dropped while sequencing off");
    seq_done_a: assert property (seqOffRequest && seqOffDone |->
        ##[1:2] !seqOffRequest)
        else $error("sequencing off did not end");
    seq_select_a: assert property ($rose(seqOffRequest) |-> $past(seqOffSelect))
        else $error("sequenced off without selection");
    temp_bit_a: assert property ((anyMeas && overTempDet
        && regSel == `SFR_SEL_STATUS_TEMP) ##1 (regSel == `SFR_SEL_STATUS_TEMP
        && !regWrStb) [*2] |=> regRdData[`SFR_STAT_OV_FAULT])
        else $error("temperature fault bit not set");
    ton_bit_a: assert property ((startupTimeoutDet
        && regSel == `SFR_SEL_STATUS_VOUT) ##1 (regSel == `SFR_SEL_STATUS_VOUT
        && !regWrStb) [*2] |=> regRdData[`SFR_STAT_TON_FAULT])
        else $error("timeout fault bit not set");

    alert_c: cover property ($fell(host_alert_line_n));
    seq_c: cover property ($rose(seqOffRequest));
    shut_c: cover property ($fell(channelEnable));
endmodule // sfr_fault_response_assertions

// [sfr_fault_response_tb.sv]
// Testbench for the fault response block
`timescale 1ns/10ps
module sfr_fault_response_tb;
    typedef struct {
        logic [2:0] idx;
        logic [7:0] act;
        logic       en;
        logic [3:0] specSel;
        logic [7:0] specMask;
        logic [3:0] sumSel;
        logic [7:0] sumMask;
    } sfr_row_type;
    sfr_row_type rows [7] = '{
        '{3'h0, 8'h00, 1'b1, 4'h9, 8'h80, 4'h5, 8'h04},
        '{3'h0, 8'h40, 1'b0, 4'h9, 8'h80, 4'h6, 8'h04},
        '{3'h1, 8'h80, 1'b0, 4'h9, 8'h10, 4'h5, 8'h04},
        '{3'h2, 8'hC0, 1'b0, 4'h8, 8'h80, 4'h7, 8'h20},
        '{3'h3, 8'h40, 1'b0, 4'h8, 8'h10, 4'h5, 8'h08},
        '{3'h4, 8'h40, 1'b0, 4'hA, 8'h04, 4'h7, 8'h80},
        '{3'h4, 8'h00, 1'b1, 4'hA, 8'h04, 4'h5, 8'h01}};
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic        measValid = 1'b0;
    logic [4:0]  det = 5'h00;
    logic        channelOnPin = 1'b0;
    logic        operationOn = 1'b0;
    logic        seqOffSelect = 1'b0;
    logic        seqOffDone = 1'b0;
    logic [2:0]  retryLimit = 3'h1;
    logic [15:0] retryDelayTicks = 16'h0002;
    logic [3:0]  regSel;
    logic        regWrStb;
    logic [7:0]  regWrData;
    logic [7:0]  regRdData;
    logic        host_alert_line_n;
    logic        channelEnable;
    logic        seqOffRequest;
    logic [7:0]  rd;
    int          num_errors = 0;
    int          checks_done = 0;

    always #20 clock = ~clock;

    sfr_fault_response #(.TICK_CYCLES(4)) dut (.clock(clock), .rst_b(rst_b),
        .measValid(measValid), .overTempDet(det[0]), .underTempDet(det[1]),
        .inputOvervoltDet(det[2]), .inputUndervoltDet(det[3]),
        .startupTimeoutDet(det[4]), .channelOnPin(channelOnPin),
        .operationOn(operationOn), .seqOffSelect(seqOffSelect),
        .seqOffDone(seqOffDone), .retryLimit(retryLimit),
        .retryDelayTicks(retryDelayTicks), .regSel(regSel), .regWrStb(regWrStb),
        .regWrData(regWrData), .regRdData(regRdData),
        .host_alert_line_n(host_alert_line_n), .channelEnable(channelEnable),
        .seqOffRequest(seqOffRequest));
    sfr_host_model host (.clock(clock), .regRdData(regRdData), .regSel(regSel),
        .regWrStb(regWrStb), .regWrData(regWrData));

    task automatic check_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic check_byte(input string what, input logic [7:0] exp,
                              input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic do_reset();
        @(posedge clock);
        rst_b <= 1'b0;
        channelOnPin <= 1'b0;
        operationOn <= 1'b0;
        seqOffSelect <= 1'b0;
        retryLimit <= 3'h1;
        retryDelayTicks <= 16'h0002;
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        cycles(1);
    endtask
    // Pin passes a two-stage synchroniser, so allow a few cycles
    task automatic power_on();
        @(posedge clock);
        channelOnPin <= 1'b1;
        operationOn <= 1'b1;
        cycles(6);
    endtask
    task automatic fault(input logic [4:0] d, input logic mv);
        @(posedge clock);
        det <= d;
        measValid <= mv;
        @(posedge clock);
        det <= 5'h00;
        measValid <= 1'b0;
        cycles(2);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        do_reset();
        check_bit("alert idle", 1'b1, host_alert_line_n);
        host.read_reg(4'h0, rd);
        check_byte("action reset", 8'h00, rd);
        foreach (rows[i]) begin
            do_reset();
            host.write_reg({1'b0, rows[i].idx}, rows[i].act);
            power_on();
            // Select the status view first so the checker sees the set edge
            host.read_reg(rows[i].specSel, rd);
            check_byte("bit idle", 8'h00, rd & rows[i].specMask);
            fault(5'h01 << rows[i].idx, 1'b1);
            check_bit("alert", 1'b0, host_alert_line_n);
            check_bit("enable", rows[i].en, channelEnable);
            host.read_reg(rows[i].specSel, rd);
            check_byte("fault bit", rows[i].specMask, rd & rows[i].specMask);
            host.read_reg(rows[i].sumSel, rd);
            check_byte("summary", rows[i].sumMask, rd & rows[i].sumMask);
        end
        do_reset();
        host.write_reg(4'h0, 8'hFF);
        host.read_reg(4'h0, rd);
        check_byte("deglitch", 8'hF8, rd);
        host.write_reg(4'h0, 8'h40);
        power_on();
        fault(5'h01, 1'b0);
        check_bit("no alert", 1'b1, host_alert_line_n);
        check_bit("still on", 1'b1, channelEnable);
        fault(5'h01, 1'b1);
        cycles(20);
        check_bit("held off", 1'b0, channelEnable);
        host.write_reg(4'h9, 8'h80);
        cycles(3);
        check_bit("alert free", 1'b1, host_alert_line_n);
        check_bit("cleared on", 1'b1, channelEnable);
        // One restart allowed, the second fault must hold
        do_reset();
        host.write_reg(4'h0, 8'h48);
        power_on();
        fault(5'h01, 1'b1);
        check_bit("off", 1'b0, channelEnable);
        cycles(30);
        check_bit("restart", 1'b1, channelEnable);
        fault(5'h01, 1'b1);
        cycles(40);
        check_bit("limit", 1'b0, channelEnable);
        host.read_reg(4'hB, rd);
        check_byte("unit state", 8'h81, rd);
        // New fault inside the restart wait stops retrying
        do_reset();
        @(posedge clock);
        retryLimit <= 3'h7;
        retryDelayTicks <= 16'h0010;
        host.write_reg(4'h0, 8'h48);
        // Timeout must shut down too, or it would not count as a new fault
        host.write_reg(4'h4, 8'h40);
        power_on();
        fault(5'h01, 1'b1);
        fault(5'h10, 1'b0);
        cycles(120);
        check_bit("stopped", 1'b0, channelEnable);
        do_reset();
        @(posedge clock);
        seqOffSelect <= 1'b1;
        host.write_reg(4'h1, 8'h40);
        power_on();
        fault(5'h02, 1'b1);
        check_bit("seq req", 1'b1, seqOffRequest);
        check_bit("seq on", 1'b1, channelEnable);
        @(posedge clock);
        seqOffDone <= 1'b1;
        @(posedge clock);
        seqOffDone <= 1'b0;
        cycles(2);
        check_bit("seq off", 1'b0, channelEnable);
        tally_and_finish();
    end
endmodule // sfr_fault_response_tb

bind sfr_fault_response sfr_fault_response_assertions #(.TICK_CYCLES(TICK_CYCLES)) chk (
    .clock(clock), .rst_b(rst_b), .measValid(measValid), .overTempDet(overTempDet),
    .underTempDet(underTempDet), .inputOvervoltDet(inputOvervoltDet),
    .inputUndervoltDet(inputUndervoltDet), .startupTimeoutDet(startupTimeoutDet),
    .channelOnPin(channelOnPin), .operationOn(operationOn),
    .seqOffSelect(seqOffSelect), .seqOffDone(seqOffDone), .retryLimit(retryLimit),
    .retryDelayTicks(retryDelayTicks), .regSel(regSel), .regWrStb(regWrStb),
    .regWrData(regWrData), .regRdData(regRdData),
    .host_alert_line_n(host_alert_line_n), .channelEnable(channelEnable),
    .seqOffRequest(seqOffRequest));

// [sfr_host_model.sv]
// Host side model driving the register port
`timescale 1ns/10ps
module sfr_host_model (
    input  wire logic       clock,
    input  wire logic [7:0] regRdData,
    output logic      [3:0] regSel,
    output logic            regWrStb,
    output logic      [7:0] regWrData
);
    initial begin
        regSel = 4'h0;
        regWrStb = 1'b0;
        regWrData = 8'h00;
    end
    task automatic write_reg(input logic [3:0] sel, input logic [7:0] data);
        @(posedge clock);
        regSel <= sel;
        regWrStb <= 1'b1;
        regWrData <= data;
        @(posedge clock);
        regWrStb <= 1'b0;
    endtask
    // Extra cycle of margin on the registered read path
    task automatic read_reg(input logic [3:0] sel, output logic [7:0] data);
        @(posedge clock);
        regSel <= sel;
        repeat (2) @(posedge clock);
        #1;
        data = regRdData;
    endtask
endmodule // sfr_host_model

// [sfr_interval.sv]
// Step counter that reports when a limit has been reached
`timescale 1ns/10ps
module sfr_interval #(
    parameter int W = 16
) (
    input  wire logic         clock,
    input  wire logic         rst_b,
    input  wire logic         tick,
    input  wire logic         clear,
    input  wire logic [W-1:0] limit,
    output logic              done
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;

    always_comb begin
        next_count = count;
        if (clear)
            next_count = '0;
        else if (tick && !done)
            next_count = count + W'(1);
    end

    // Level, so a zero limit ends at once
    assign done = (count >= limit);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b)
            count <= '0;
        else
            count <= next_count;
    end
endmodule // sfr_interval

// [sfr_pkg.sv]
// Types shared by the fault response block
package sfr_pkg;

    typedef enum logic [4:0] {
        SFR_OFF        = 5'h01,
        SFR_RUN        = 5'h02,
        SFR_SEQ_OFF    = 5'h04,
        SFR_RETRY_WAIT = 5'h08,
        SFR_HOLD       = 5'h10
    } sfr_state_type;

    typedef logic [4:0] sfr_fault_type;

endpackage

// [sfr_regs.svh]
// Offsets, field positions, reset values and timing counts of the fault response block
`ifndef SFR_REGS_SVH
`define SFR_REGS_SVH

// Register selects on the command port
`define SFR_SEL_OT_ACTION     4'h0
`define SFR_SEL_UT_ACTION     4'h1
`define SFR_SEL_VIN_OV_ACTION 4'h2
`define SFR_SEL_VIN_UV_ACTION 4'h3
`define SFR_SEL_TON_ACTION    4'h4
`define SFR_SEL_STATUS_BYTE   4'h5
`define SFR_SEL_WORD_LOW      4'h6
`define SFR_SEL_WORD_HIGH     4'h7
`define SFR_SEL_STATUS_VIN    4'h8
`define SFR_SEL_STATUS_TEMP   4'h9
`define SFR_SEL_STATUS_VOUT   4'hA
`define SFR_SEL_UNIT_STATE    4'hB

// Response setting fields
`define SFR_ACTION_MSB   7
`define SFR_ACTION_LSB   6
`define SFR_RETRY_MSB    5
`define SFR_RETRY_LSB    3
`define SFR_ACTION_RESET 8'h00
`define SFR_DEGLITCH_RD  3'h0

// Fault index within the sticky vector
`define SFR_IDX_OT     0
`define SFR_IDX_UT     1
`define SFR_IDX_VIN_OV 2
`define SFR_IDX_VIN_UV 3
`define SFR_IDX_TON    4

// Status bit positions
`define SFR_BYTE_HIGH_BYTE  0
`define SFR_BYTE_TEMP       2
`define SFR_BYTE_VIN_UV     3
`define SFR_HIGH_VOUT       7
`define SFR_HIGH_INPUT      5
`define SFR_STAT_OV_FAULT   7
`define SFR_STAT_UV_FAULT   4
`define SFR_STAT_TON_FAULT  2

// Restart limit meaning
`define SFR_RETRY_INFINITE  3'h7

// Timing
`define SFR_CLK_MHZ        25
`define SFR_TICK_US        200
`define SFR_TICK_CYCLES    (`SFR_TICK_US * `SFR_CLK_MHZ)
`define SFR_RETRY_MAX_US   13100000
`define SFR_RETRY_MAX_TICK (`SFR_RETRY_MAX_US / `SFR_TICK_US)
`define SFR_QUIET_US       6000000
`define SFR_QUIET_TICK     (`SFR_QUIET_US / `SFR_TICK_US)

`endif

// [sfr_tick_div.sv]
// Divider that makes the 200 us step enable
`timescale 1ns/10ps
`include "sfr_regs.svh"
module sfr_tick_div #(
    parameter int TICK_CYCLES = `SFR_TICK_CYCLES
) (
    input  wire logic clock,
    input  wire logic rst_b,
    output logic      tick
);
    logic [15:0] count;
    logic [15:0] next_count;
    logic        next_tick;

    always_comb begin
        next_tick  = (count == 16'(TICK_CYCLES - 1));
        next_count = next_tick ? 16'h0000 : count + 16'h0001;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            count <= 16'h0000;
            tick  <= 1'b0;
        end else begin
            count <= next_count;
            tick  <= next_tick;
        end
    end
endmodule // sfr_tick_div
